// ==== hw/tbp_pkg.sv ====
// Purpose: types of the trace buffer readout block
// Assumes: tbp_regs.svh gives the sizes
// Notes:   all state of the block lives in one packed struct
`include "tbp_regs.svh"
package tbp_pkg;

  typedef enum logic [1:0] {
    TBP_NORMAL,
    TBP_LOOP1,
    TBP_DETAIL,
    TBP_COMPRESSED
  } tbp_mode_t;

  typedef struct packed {
    logic                                     sec_s1;
    logic                                     sec_s2;
    logic                                     arm;
    logic                                     tss;
    tbp_mode_t                                mode;
    logic                                     unlocked;
    logic [`TBP_PTR_W-1:0]                    wr_ptr;
    logic                                     ovf;
    logic [`TBP_CNT_W-1:0]                    cnt;
    logic                                     base_valid;
    logic [11:0]                              base_hi;
    logic [1:0]                               open_cnt;
    logic [`TBP_PTR_W-1:0]                    open_line;
    logic [`TBP_PTR_W-1:0]                    rd_ptr;
    logic                                     rd_half;
    logic                                     wait_r;
    logic [31:0]                              rdata;
    logic [`TBP_DEPTH-1:0][`TBP_LINE_W-1:0]   mem;
  } tbp_state_t;

endpackage

// ==== hw/tbp_regs.svh ====
// Purpose: register offsets, field positions, reset values and sizes of the trace buffer
// Assumes: 32-bit Avalon-MM data bus with byte addresses
// Notes:   definitions only
`ifndef TBP_REGS_SVH
`define TBP_REGS_SVH

// register byte offsets
`define TBP_OFF_CTRL      4'h0
`define TBP_OFF_COUNT     4'h4
`define TBP_OFF_DATA      4'h8
`define TBP_OFF_DATA_HI   4'hC

// buffer geometry
`define TBP_DEPTH         64
`define TBP_PTR_W         6
`define TBP_LINE_W        20
`define TBP_CNT_W         7
`define TBP_CNT_FULL      7'h40
`define TBP_PTR_LAST      6'h3F

// control register fields
`define TBP_CTRL_ARM      0
`define TBP_CTRL_TSS      1
`define TBP_CTRL_MODE_LO  2
`define TBP_CTRL_MODE_HI  3

// line count register fields
`define TBP_CNT_OVF       7
`define TBP_CNT_UNLK      8

// row layout
`define TBP_ROW_HI        19
`define TBP_ROW_LO        18
`define TBP_INFO_BASE     2'h0
`define TBP_INFO_ONE      2'h1
`define TBP_INFO_TWO      2'h2
`define TBP_INFO_THREE    2'h3

// byte enable pattern of an aligned 16-bit word access
`define TBP_BE_WORD       4'h3

// reset values
`define TBP_PTR_RST       6'h00
`define TBP_RDATA_RST     32'h0000_0000
`endif

// ==== hw/tbp_trace_buffer.sv ====
// Purpose: debug trace buffer row packing and software readout over Avalon-MM
// Assumes: trace events come from logic on clk_i; secured_i is an asynchronous pin
// Notes:   buffer, line count, overflow flag and write pointer survive reset_i
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`include "tbp_regs.svh"

// Summary of operation
// R1 - normal modes: row bit 3 of info is 0 for source, 1 for destination.
// R2 - info bit 2 marks a vector entry; vector entries always have destination bit set.
// R3 - info bits 1:0 hold program counter bits 17 and 16.
// R4 - compressed rows are 2 info bits then three 6-bit fields 2, 1, 0.
// R5 - info 00 row holds a full 18-bit base program counter.
// R6 - info 01, 10, 11 hold one, two, three offsets from the block base.
// R7 - a change in program counter bits 17:6 stores a new full base row.
// R8 - offsets count from the lowest address of the aligned 64-address block.
// R9 - line 0 always receives a full base row, also after wrap.
// R10 - readable only when disarmed, tracing source set and not secured.
// R11 - arming locks reading; an aligned word write to data unlocks when disarmed.
// R12 - byte or misaligned data reads return 0 and leave the pointer.
// R13 - readout oldest first; line count does not drop while reading.
// R14 - read pointer starts at line 0, or at oldest line after overflow.
// R15 - after compressed wrap, oldest row info marks which fields are newer.
// R16 - aligned word write to high data register restarts readout at oldest.
// R17 - each line reads as two words: row bits 15:0, then row bits 19:16 in [3:0].
// R18 - data reads while armed give no valid data and keep the pointer.
// R19 - reset keeps contents and count; unlock repositions pointer to oldest.
// R20 - with tracing source clear, every buffer read returns zero.
// R21 - write pointer wraps modulo depth; first wrap sets the overflow flag.
module tbp_trace_buffer
  import tbp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [3:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [3:0]  byteenable_i,
  input  wire logic [31:0] writedata_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o,
  input  wire logic        secured_i,
  input  wire logic        trace_valid_i,
  input  wire logic [17:0] trace_pc_i,
  input  wire logic        trace_dest_i,
  input  wire logic        trace_vector_i,
  output logic             armed_o
);

  tbp_state_t st_r;
  tbp_state_t st_nxt;

  logic                  req;
  logic                  acc;
  logic                  is_data;
  logic                  word;
  logic                  readable;
  logic                  push;
  logic                  need_base;
  logic [`TBP_PTR_W-1:0] widx;
  logic [`TBP_LINE_W-1:0] row;
  logic [`TBP_LINE_W-1:0] old;
  logic [`TBP_LINE_W-1:0] cur;
  logic [31:0]           rv;

  // aligned 16-bit word access in the low lanes
  function automatic logic is_word(input logic [3:0] be);
    return be == `TBP_BE_WORD;
  endfunction

  // line holding the oldest entry of the session
  function automatic logic [`TBP_PTR_W-1:0] oldest_line(input logic                  ovf,
                                                        input logic [`TBP_PTR_W-1:0] wr);
    return ovf ? wr : `TBP_PTR_RST;
  endfunction

  assign readdata_o    = st_r.rdata;
  assign waitrequest_o = st_r.wait_r;
  assign armed_o       = st_r.arm;

  // next state: synchroniser, capture, bus slave, reset
  always_comb begin
    st_nxt    = st_r;
    req       = read_i | write_i;
    acc       = req & ~st_r.wait_r;
    is_data   = address_i == `TBP_OFF_DATA;
    word      = is_word(byteenable_i);
    readable  = ~st_r.arm & st_r.tss & ~st_r.sec_s2 & st_r.unlocked;  // [R10]
    push      = 1'b0;
    need_base = 1'b0;
    widx      = st_r.wr_ptr;
    row       = '0;
    old       = '0;
    cur       = st_r.mem[st_r.rd_ptr];
    rv        = `TBP_RDATA_RST;

    // secure pin, two flops before use
    st_nxt.sec_s1 = secured_i;
    st_nxt.sec_s2 = st_r.sec_s1;

    // trace capture while armed
    if (st_r.arm && trace_valid_i) begin
      case (st_r.mode)
        TBP_COMPRESSED: begin
          // a new line at line 0 must be a base row
          need_base = ~st_r.base_valid
                    | (trace_pc_i[17:6] != st_r.base_hi)                      // [R7]
                    | (((st_r.open_cnt == 2'h0) | (st_r.open_cnt == `TBP_INFO_THREE))
                       & (st_r.wr_ptr == `TBP_PTR_RST));                      // [R9]
          if (need_base) begin
            row               = {`TBP_INFO_BASE, trace_pc_i};                 // [R5]
            push              = 1'b1;
            st_nxt.base_hi    = trace_pc_i[17:6];                             // [R8]
            st_nxt.base_valid = 1'b1;
            st_nxt.open_cnt   = 2'h0;
          end else if ((st_r.open_cnt == 2'h0) || (st_r.open_cnt == `TBP_INFO_THREE)) begin
            // older fields kept after wrap so info shows which are newer
            old              = st_r.ovf ? st_r.mem[st_r.wr_ptr] : '0;        // [R15]
            row              = {`TBP_INFO_ONE, old[17:6], trace_pc_i[5:0]};   // [R6]
            push             = 1'b1;
            st_nxt.open_line = st_r.wr_ptr;
            st_nxt.open_cnt  = 2'h1;
          end else begin
            // grow the open row in place, field 0 oldest
            widx = st_r.open_line;
            old  = st_r.mem[st_r.open_line];
            if (st_r.open_cnt == 2'h1) begin
              row = {`TBP_INFO_TWO, old[17:12], trace_pc_i[5:0], old[5:0]};  // [R6] [R15]
            end else begin
              row = {`TBP_INFO_THREE, trace_pc_i[5:0], old[11:0]};           // [R4] [R6]
            end
            st_nxt.open_cnt = st_r.open_cnt + 2'h1;
          end
        end
        default: begin
          // branch tracing row: flags then all 18 program counter bits
          row = {trace_dest_i | trace_vector_i,                              // [R1] [R2]
                 trace_vector_i,                                             // [R2]
                 trace_pc_i};                                                // [R3]
          push = 1'b1;
        end
      endcase
      st_nxt.mem[widx] = row;
      if (push) begin
        st_nxt.wr_ptr = st_r.wr_ptr + 6'h01;                                 // [R21]
        if (st_r.wr_ptr == `TBP_PTR_LAST) begin
          st_nxt.ovf = 1'b1;                                                 // [R21]
        end
        if (st_r.cnt != `TBP_CNT_FULL) begin
          st_nxt.cnt = st_r.cnt + 7'h01;
        end
      end
    end

    // read value, formed while the request waits
    case (address_i)
      `TBP_OFF_CTRL: begin
        rv = {28'h0000000, st_r.mode, st_r.tss, st_r.arm};
      end
      `TBP_OFF_COUNT: begin
        rv = {23'h000000, st_r.unlocked, st_r.ovf, st_r.cnt};
      end
      `TBP_OFF_DATA: begin
        if (word && readable) begin                                          // [R12] [R18] [R20]
          rv = st_r.rd_half ? {28'h0000000, cur[19:16]}                      // [R17]
                            : {16'h0000, cur[15:0]};                         // [R17]
        end
      end
      default: begin
        rv = `TBP_RDATA_RST;
      end
    endcase

    // one wait state, then the access completes
    st_nxt.wait_r = 1'b1;
    if (req && st_r.wait_r) begin
      st_nxt.wait_r = 1'b0;
      st_nxt.rdata  = rv;
    end

    // write side effects at the completing edge
    if (acc && write_i) begin
      case (address_i)
        `TBP_OFF_CTRL: begin
          if (byteenable_i[0]) begin
            st_nxt.arm  = writedata_i[`TBP_CTRL_ARM];
            st_nxt.tss  = writedata_i[`TBP_CTRL_TSS];
            st_nxt.mode = tbp_mode_t'(writedata_i[`TBP_CTRL_MODE_HI:`TBP_CTRL_MODE_LO]);
            if (writedata_i[`TBP_CTRL_ARM]) begin
              st_nxt.unlocked = 1'b0;                                        // [R11]
            end
            // new session on arming
            if (writedata_i[`TBP_CTRL_ARM] && !st_r.arm) begin
              st_nxt.wr_ptr     = `TBP_PTR_RST;
              st_nxt.cnt        = '0;
              st_nxt.ovf        = 1'b0;
              st_nxt.base_valid = 1'b0;
              st_nxt.open_cnt   = 2'h0;
            end
          end
        end
        `TBP_OFF_DATA: begin
          if (word && !st_r.arm) begin
            st_nxt.unlocked = 1'b1;                                          // [R11]
            st_nxt.rd_ptr   = oldest_line(st_r.ovf, st_r.wr_ptr);            // [R14] [R19]
            st_nxt.rd_half  = 1'b0;
          end
        end
        `TBP_OFF_DATA_HI: begin
          if (word) begin
            st_nxt.rd_ptr  = oldest_line(st_r.ovf, st_r.wr_ptr);             // [R16]
            st_nxt.rd_half = 1'b0;
          end
        end
        default: begin
          st_nxt.rd_half = st_r.rd_half;
        end
      endcase
    end

    // pointer advances only on a valid aligned data read
    if (acc && read_i && is_data && word && readable) begin                 // [R12] [R18]
      st_nxt.rd_half = ~st_r.rd_half;                                        // [R17]
      if (st_r.rd_half) begin
        st_nxt.rd_ptr = st_r.rd_ptr + 6'h01;                                 // [R13]
      end
    end

    // reset keeps buffer, count, overflow and write pointer
    if (reset_i) begin
      st_nxt.sec_s1     = 1'b0;
      st_nxt.sec_s2     = 1'b0;
      st_nxt.arm        = 1'b0;
      st_nxt.tss        = 1'b0;
      st_nxt.mode       = TBP_NORMAL;
      st_nxt.unlocked   = 1'b0;
      st_nxt.base_valid = 1'b0;
      st_nxt.open_cnt   = 2'h0;
      st_nxt.open_line  = `TBP_PTR_RST;
      st_nxt.rd_ptr     = `TBP_PTR_RST;
      st_nxt.rd_half    = 1'b0;
      st_nxt.wait_r     = 1'b1;
      st_nxt.rdata      = `TBP_RDATA_RST;                                    // [R19]
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    st_r <= st_nxt;
  end

  // checks
  property p_dest_bit;
    @(posedge clk_i) disable iff (reset_i)
    (st_r.arm && trace_valid_i && st_r.mode != TBP_COMPRESSED && !trace_vector_i)
    |=> st_r.mem[$past(st_r.wr_ptr)][`TBP_ROW_HI] == $past(trace_dest_i);
  endproperty
  a_dest_bit: assert property (p_dest_bit) else $error("source/destination flag wrong"); // [R1]

  property p_vector_dest;
    @(posedge clk_i) disable iff (reset_i)
    (st_r.arm && trace_valid_i && st_r.mode != TBP_COMPRESSED && trace_vector_i)
    |=> st_r.mem[$past(st_r.wr_ptr)][`TBP_ROW_HI:`TBP_ROW_LO] == 2'h3;
  endproperty
  a_vector_dest: assert property (p_vector_dest) else $error("vector row lacks dest flag"); // [R2]

  property p_pc_hi;
    @(posedge clk_i) disable iff (reset_i)
    (st_r.arm && trace_valid_i && st_r.mode != TBP_COMPRESSED)
    |=> st_r.mem[$past(st_r.wr_ptr)][17:16] == $past(trace_pc_i[17:16]);
  endproperty
  a_pc_hi: assert property (p_pc_hi) else $error("upper pc bits not stored"); // [R3]

  property p_new_base;
    @(posedge clk_i) disable iff (reset_i)
    (st_r.arm && trace_valid_i && st_r.mode == TBP_COMPRESSED && st_r.base_valid
     && trace_pc_i[17:6] != st_r.base_hi)
    |=> st_r.mem[$past(st_r.wr_ptr)] == {`TBP_INFO_BASE, $past(trace_pc_i)};
  endproperty
  a_new_base: assert property (p_new_base) else $error("base row not stored"); // [R7]

  property p_line0_base;
    @(posedge clk_i) disable iff (reset_i)
    (st_r.arm && trace_valid_i && st_r.mode == TBP_COMPRESSED && st_r.wr_ptr == 6'h00
     && (st_r.open_cnt == 2'h0 || st_r.open_cnt == 2'h3))
    |=> st_r.mem[0][`TBP_ROW_HI:`TBP_ROW_LO] == `TBP_INFO_BASE;
  endproperty
  a_line0_base: assert property (p_line0_base) else $error("line 0 not a base row"); // [R9]

  property p_bad_read_zero;
    @(posedge clk_i) disable iff (reset_i)
    (read_i && st_r.wait_r && is_data && (!word || !st_r.tss))
    |=> readdata_o == 32'h0000_0000 && !waitrequest_o;
  endproperty
  a_bad_read_zero: assert property (p_bad_read_zero) else $error("bad data read not zero"); // [R12]

  property p_armed_keep;
    @(posedge clk_i) disable iff (reset_i)
    (acc && read_i && is_data && (st_r.arm || !word))
    |=> $stable(st_r.rd_ptr) && $stable(st_r.rd_half);
  endproperty
  a_armed_keep: assert property (p_armed_keep) else $error("read pointer moved"); // [R18]

  property p_count_kept;
    @(posedge clk_i) disable iff (reset_i)
    (acc && read_i && !st_r.arm) |=> $stable(st_r.cnt);
  endproperty
  a_count_kept: assert property (p_count_kept) else $error("line count changed on read"); // [R13]

  property p_restart;
    @(posedge clk_i) disable iff (reset_i)
    (acc && write_i && address_i == `TBP_OFF_DATA_HI && word)
    |=> st_r.rd_ptr == ($past(st_r.ovf) ? $past(st_r.wr_ptr) : 6'h00) && !st_r.rd_half;
  endproperty
  a_restart: assert property (p_restart) else $error("readout not restarted"); // [R16]

  property p_wrap_ovf;
    @(posedge clk_i) disable iff (reset_i)
    (push && st_r.wr_ptr == 6'h3F && !(acc && write_i)) |=> st_r.ovf && st_r.wr_ptr == 6'h00;
  endproperty
  a_wrap_ovf: assert property (p_wrap_ovf) else $error("wrap did not flag overflow"); // [R21]

  // readout side: word format, refused reads and pointer placement
  property p_word_format;
    @(posedge clk_i) disable iff (reset_i)
    (read_i && st_r.wait_r && is_data && word && readable)
    |=> readdata_o[31:16] == 16'h0000 && (!$past(st_r.rd_half) || readdata_o[15:4] == 12'h000);
  endproperty
  a_word_format: assert property (p_word_format) else $error("line word format wrong"); // [R17]

  property p_locked_zero;
    @(posedge clk_i) disable iff (reset_i)
    (read_i && st_r.wait_r && is_data && !st_r.unlocked) |=> readdata_o == 32'h0000_0000;
  endproperty
  a_locked_zero: assert property (p_locked_zero) else $error("locked buffer gave data"); // [R11]

  property p_secured_zero;
    @(posedge clk_i) disable iff (reset_i)
    (read_i && st_r.wait_r && is_data && st_r.sec_s2) |=> readdata_o == 32'h0000_0000;
  endproperty
  a_secured_zero: assert property (p_secured_zero) else $error("secured read gave data"); // [R10]

  property p_armed_zero;
    @(posedge clk_i) disable iff (reset_i)
    (read_i && st_r.wait_r && is_data && st_r.arm) |=> readdata_o == 32'h0000_0000;
  endproperty
  a_armed_zero: assert property (p_armed_zero) else $error("armed read gave data"); // [R18]

  property p_unlock_ptr;
    @(posedge clk_i) disable iff (reset_i)
    (acc && write_i && is_data && word && !st_r.arm)
    |=> st_r.unlocked && st_r.rd_ptr == ($past(st_r.ovf) ? $past(st_r.wr_ptr) : 6'h00);
  endproperty
  a_unlock_ptr: assert property (p_unlock_ptr) else $error("unlock pointer not at oldest"); // [R14]

  property p_arm_lock;
    @(posedge clk_i) disable iff (reset_i)
    (acc && write_i && address_i == `TBP_OFF_CTRL && byteenable_i[0]
     && writedata_i[`TBP_CTRL_ARM])
    |=> st_r.arm && !st_r.unlocked;
  endproperty
  a_arm_lock: assert property (p_arm_lock) else $error("arming did not lock buffer"); // [R11]

  c_rollover_unlock: cover property (@(posedge clk_i) disable iff (reset_i)
    acc && write_i && is_data && word && !st_r.arm && st_r.ovf);

  c_unlock: cover property (@(posedge clk_i) disable iff (reset_i)
    acc && write_i && is_data && word && !st_r.arm);
  c_line_read: cover property (@(posedge clk_i) disable iff (reset_i)
    acc && read_i && is_data && readable && st_r.rd_half);
  c_wrap: cover property (@(posedge clk_i) disable iff (reset_i)
    push && st_r.wr_ptr == 6'h3F);
  c_three: cover property (@(posedge clk_i) disable iff (reset_i)
    st_r.arm && trace_valid_i && st_r.mode == TBP_COMPRESSED && st_r.open_cnt == 2'h2
    && !need_base);

endmodule

// ==== test/tbp_host_model.sv ====
// Purpose: Avalon-MM master standing in for the debug host that reads the trace buffer
// Assumes: the slave drops waitrequest for one cycle to finish an access
// Notes:   after the time-zero idle values, signals change only by non-blocking assignment just after a rising edge
module tbp_host_model (
  input  wire logic        clk_i,
  output logic      [3:0]  address_o,
  output logic             read_o,
  output logic             write_o,
  output logic      [3:0]  byteenable_o,
  output logic      [31:0] writedata_o,
  input  wire logic [31:0] readdata_i,
  input  wire logic        waitrequest_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial begin
    address_o    = 4'h0;
    read_o       = 1'b0;
    write_o      = 1'b0;
    byteenable_o = 4'h0;
    writedata_o  = 32'h0000_0000;
  end

  // one access, held until waitrequest is sampled low at a rising edge
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [3:0] be,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    address_o    <= a;
    read_o       <= !wr;
    write_o      <= wr;
    byteenable_o <= be;
    writedata_o  <= wd;
    do @(posedge clk_i); while (waitrequest_i !== 1'b0);
    rd = readdata_i;
    read_o       <= 1'b0;
    write_o      <= 1'b0;
    // released address and write data lines no longer show the last value; byteenable keeps it
    address_o    <= ~a;
    writedata_o  <= ~wd;
  endtask
endmodule

// ==== test/trace_buffer_pack_readout_tb.sv ====
// Purpose: self-checking bench of trace row packing and software readout
// Assumes: one wait state per access; events are taken only while armed
// Notes:   expected rows are rebuilt here from the random event stream
`include "tbp_regs.svh"
module trace_buffer_pack_readout_tb import tbp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [3:0]  address;
  logic        read;
  logic        write;
  logic [3:0]  byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        armed;
  logic        secured_i = 1'b0;
  logic        trace_valid_i = 1'b0;
  logic [17:0] trace_pc_i = 18'h0_0000;
  logic        trace_dest_i = 1'b0;
  logic        trace_vector_i = 1'b0;
  int          mismatches = 0;
  int          checks_done = 0;
  int unsigned seed_tap;
  logic [19:0] exp_q[$];
  logic [19:0] msk_q[$];
  logic [31:0] d;
  logic [17:0] pc;

  tbp_trace_buffer u_tbp_trace_buffer (
    .clk_i(clk_i), .reset_i(reset_i), .address_i(address), .read_i(read),
    .write_i(write), .byteenable_i(byteenable), .writedata_i(writedata),
    .readdata_o(readdata), .waitrequest_o(waitrequest), .secured_i(secured_i),
    .trace_valid_i(trace_valid_i), .trace_pc_i(trace_pc_i), .trace_dest_i(trace_dest_i),
    .trace_vector_i(trace_vector_i), .armed_o(armed)
  );
  tbp_host_model u_tbp_host_model (
    .clk_i(clk_i), .address_o(address), .read_o(read), .write_o(write),
    .byteenable_o(byteenable), .writedata_o(writedata), .readdata_i(readdata),
    .waitrequest_i(waitrequest)
  );

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  // counts, verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] wd);
    logic [31:0] x;
    u_tbp_host_model.xfer(1'b1, a, `TBP_BE_WORD, wd, x);
  endtask

  task automatic rd(input logic [3:0] a, input logic [3:0] be, output logic [31:0] v);
    u_tbp_host_model.xfer(1'b0, a, be, 32'h0000_0000, v);
  endtask

  // one line is two word reads: row bits 15:0 first, then row bits 19:16 in [3:0]
  task automatic getrow(output logic [19:0] row);
    logic [31:0] lo;
    logic [31:0] hi;
    rd(`TBP_OFF_DATA, `TBP_BE_WORD, lo);
    rd(`TBP_OFF_DATA, `TBP_BE_WORD, hi);
    chk({16'h0000, lo[31:16]} | {hi[31:4], 4'h0}, 32'h0000_0000);
    row = {hi[3:0], lo[15:0]};
  endtask

  // one trace event per cycle; back to back calls keep valid high
  task automatic ev(input logic [17:0] p, input logic dst, input logic vec);
    @(posedge clk_i);
    trace_valid_i  <= 1'b1;
    trace_pc_i     <= p;
    trace_dest_i   <= dst;
    trace_vector_i <= vec;
  endtask

  task automatic ev_end();
    @(posedge clk_i);
    trace_valid_i <= 1'b0;
    trace_pc_i    <= ~trace_pc_i;
  endtask

  // branch-trace session of n random events, then disarm
  task automatic norm_run(input logic [1:0] m, input int n);
    logic dst;
    logic vec;
    exp_q.delete();
    wr(`TBP_OFF_CTRL, {28'h0, m, 2'b11});
    @(negedge clk_i);
    chk(32'(armed), 32'h0000_0001);
    for (int i = 0; i < n; i++) begin
      pc = 18'($urandom);
      dst = 1'($urandom);
      vec = 1'($urandom);
      exp_q.push_back({dst | vec, vec, pc});
      ev(pc, dst, vec);
    end
    ev_end();
    wr(`TBP_OFF_CTRL, {28'h0, m, 2'b10});
    @(negedge clk_i);
    chk(32'(armed), 32'h0000_0000);
  endtask

  // watchdog well beyond the expected run length
  initial begin
    repeat (50000) @(posedge clk_i);
    mismatches++;
    conclude();
  end

  // main sequence
  initial begin
    logic [19:0] row;
    logic [11:0] hi;
    logic [5:0]  o;
    int          nz;
    int          hit;
    seed_tap = $urandom(94);
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int m = 0; m < 3; m++) begin
      norm_run(2'(m), 10);
      rd(`TBP_OFF_COUNT, `TBP_BE_WORD, d);
      chk(d, 32'h0000_000A);
      rd(`TBP_OFF_DATA, `TBP_BE_WORD, d);
      chk(d, 32'h0000_0000);
      wr(`TBP_OFF_DATA, 32'h0000_0000);
      rd(`TBP_OFF_DATA, 4'h1, d);
      chk(d, 32'h0000_0000);
      rd(`TBP_OFF_DATA, 4'hC, d);
      chk(d, 32'h0000_0000);
      foreach (exp_q[i]) begin
        getrow(row);
        chk(32'(row), 32'(exp_q[i]));
      end
      rd(`TBP_OFF_COUNT, `TBP_BE_WORD, d);
      chk(d, 32'h0000_010A);
      wr(`TBP_OFF_DATA_HI, 32'h0000_0000);
      getrow(row);
      chk(32'(row), 32'(exp_q[0]));
      secured_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rd(`TBP_OFF_DATA, `TBP_BE_WORD, d);
      chk(d, 32'h0000_0000);
      secured_i <= 1'b0;
      $display("test branch mode %0d done", m);
    end
    // reset keeps contents; tracing source must be set again to read
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(`TBP_OFF_COUNT, `TBP_BE_WORD, d);
    chk(d, 32'h0000_000A);
    wr(`TBP_OFF_DATA, 32'h0000_0000);
    rd(`TBP_OFF_DATA, `TBP_BE_WORD, d);
    chk(d, 32'h0000_0000);
    wr(`TBP_OFF_CTRL, 32'h0000_0002);
    getrow(row);
    chk(32'(row), 32'(exp_q[0]));
    $display("test reset retention done");
    // overflow: 70 events into 64 lines
    norm_run(2'b00, 70);
    rd(`TBP_OFF_COUNT, `TBP_BE_WORD, d);
    chk(d, 32'h0000_00C0);
    wr(`TBP_OFF_DATA, 32'h0000_0000);
    getrow(row);
    chk(32'(row), 32'(exp_q[6]));
    getrow(row);
    chk(32'(row), 32'(exp_q[7]));
    wr(`TBP_OFF_CTRL, 32'h0000_0003);
    rd(`TBP_OFF_DATA, `TBP_BE_WORD, d);
    chk(d, 32'h0000_0000);
    wr(`TBP_OFF_CTRL, 32'h0000_0002);
    $display("test overflow done");
    // compressed: four blocks with 3, 2, 1, 0 offsets after each base
    exp_q.delete();
    msk_q.delete();
    wr(`TBP_OFF_CTRL, 32'h0000_000F);
    hi = 12'($urandom);
    for (int b = 0; b < 4; b++) begin
      pc = {hi + 12'(b), 6'($urandom)};
      ev(pc, 1'b0, 1'b0);
      exp_q.push_back({2'b00, pc});
      msk_q.push_back(20'hF_FFFF);
      row = {2'(3 - b), 18'h0_0000};
      for (int k = 0; k < 3 - b; k++) begin
        o = 6'($urandom);
        ev({pc[17:6], o}, 1'b0, 1'b0);
        row[6*k +: 6] = o;
      end
      if (b < 3) begin
        exp_q.push_back(row);
        msk_q.push_back({2'b11, 18'h3_FFFF >> (6 * b)});
      end
    end
    ev_end();
    wr(`TBP_OFF_CTRL, 32'h0000_000E);
    rd(`TBP_OFF_COUNT, `TBP_BE_WORD, d);
    chk(d, 32'h0000_0007);
    wr(`TBP_OFF_DATA, 32'h0000_0000);
    foreach (exp_q[i]) begin
      getrow(row);
      chk(32'(row & msk_q[i]), 32'(exp_q[i] & msk_q[i]));
    end
    $display("test compressed rows done");
    // compressed wrap: an offset event landing on line 0 becomes a base row
    wr(`TBP_OFF_CTRL, 32'h0000_000F);
    for (int b = 0; b < 64; b++) ev({12'(b), 6'h00}, 1'b0, 1'b0);
    ev({12'h03F, 6'h05}, 1'b0, 1'b0);
    ev_end();
    wr(`TBP_OFF_CTRL, 32'h0000_000E);
    rd(`TBP_OFF_COUNT, `TBP_BE_WORD, d);
    chk(d, 32'h0000_00C0);
    wr(`TBP_OFF_DATA, 32'h0000_0000);
    nz = 0;
    hit = 0;
    for (int i = 0; i < 64; i++) begin
      getrow(row);
      if (row[19:18] !== 2'b00) nz++;
      if (row === {2'b00, 12'h03F, 6'h05}) hit++;
    end
    chk(32'(nz), 32'h0000_0000);
    chk(32'(hit), 32'h0000_0001);
    $display("test compressed wrap done");
    conclude();
  end
endmodule
